// file: verilog/mdl_pkg.sv
// Shared constants for the de-skew loopback and mode configuration block
`default_nettype none
package mdl_pkg;

  // ==========================================================================
  // Pin vector layout, one sample per clock edge (unmirrored pin naming)
  localparam int MDL_PIN_W = 20;
  localparam int MDL_ADDR_W = 14;
  localparam int MDL_IDX_CS = 14;
  localparam int MDL_IDX_WE = 15;
  localparam int MDL_IDX_REF = 16;
  localparam int MDL_IDX_DPR = 17;
  localparam int MDL_IDX_DK0 = 18;
  localparam int MDL_IDX_DK1 = 19;

  // ==========================================================================
  // Echo outputs: 27 data bits plus 3 invert flags
  localparam int MDL_DQ_W = 27;
  localparam int MDL_DATA_INVERT_FLAG_W = 3;
  localparam int MDL_OUT_W = 30;
  localparam logic MDL_X36 = 1'b1; // Part width: 1 = x36, 0 = x18

  // ==========================================================================
  // Command codes on {select, write enable, refresh}, all active low
  localparam logic [2:0] MDL_CMD_MRS = 3'h0;
  localparam logic [2:0] MDL_CMD_WRITE = 3'h1;
  localparam logic [2:0] MDL_CMD_REFRESH = 3'h2;
  localparam logic [2:0] MDL_CMD_READ = 3'h3;

  // ==========================================================================
  // Mode register layout: {1'b0, beat0 A5..A3, beat1 A5..A0}
  localparam int MDL_NUM_REGS = 4;
  localparam int MDL_CFG_W = 10;
  localparam int MDL_R0_BL_LO = 0;
  localparam int MDL_R0_RM = 2;
  localparam int MDL_R0_FZ = 3;
  localparam int MDL_R0_DI = 4;
  localparam int MDL_R0_SPEED_LO = 6;
  localparam int MDL_R1_PLL = 0;
  localparam int MDL_R1_ADM = 6;
  localparam int MDL_R1_DMP_LO = 7;
  localparam logic [1:0] MDL_DMP_BEAT0 = 2'h0;
  localparam logic [1:0] MDL_DMP_BEAT1 = 2'h2;

  // Reset values: burst length code 01, speed config 2, all enables off
  localparam logic [9:0] MDL_CFG0_RST = 10'h081;
  localparam logic [9:0] MDL_CFG1_RST = 10'h000;
  localparam logic [9:0] MDL_CFG2_RST = 10'h000;
  localparam logic [9:0] MDL_CFG3_RST = 10'h000;

  typedef enum logic {MDL_MRS_IDLE, MDL_MRS_BEAT1} mdl_mrs_t;

endpackage : mdl_pkg
`default_nettype wire

// file: verilog/mdl_deskew_cfg.sv
// Loopback de-skew echo path and mode-register-set configuration
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Echo select low loops inputs onto outputs
// - Echo mapping follows width, not mirror level
// - Write clock loops receiver output, not legs
// - Rising capture echoed unmodified on rising
// - Falling capture echoed inverted on falling
// - No bus inversion during loopback
// - Loopback latency is five command clocks
// - Commands ignored while echo select low
// - Self refresh runs throughout loopback
// - PLL bypassed during loopback
// - Loopback never changes PLL enable setting
// - Training leaves memory contents untouched
// - Auto-mask writes only the selected beat
// - Mode set loads one of four registers
// - Register number from beat-0 address bits 2..0
// - Mode address pins swap with mirror level
// - Mode settings reset to documented defaults
// - Pattern 00 beat0, 10 beat1, else none
// - Refresh mode 0 auto, 1 overlapped strobe
module mdl_deskew_cfg
  import mdl_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic read_data_clock,
  input wire logic echo_select_n,
  input wire logic mirror_flip,
  input wire logic [13:0] addr_rise,
  input wire logic [13:0] addr_fall,
  input wire logic [3:0] ctl_n_rise,
  input wire logic [3:0] ctl_n_fall,
  input wire logic [1:0] write_data_clock_rise,
  input wire logic [1:0] write_data_clock_fall,
  output logic [26:0] echo_dq_rise,
  output logic [26:0] echo_dq_fall,
  output logic [2:0] echo_invert_rise,
  output logic [2:0] echo_invert_fall,
  output logic [26:0] dq_rise_out,
  output logic [26:0] dq_fall_out,
  output logic [2:0] data_invert_flag_rise,
  output logic [2:0] data_invert_flag_fall,
  output logic link_echo_active,
  output logic loopback_active,
  output logic self_refresh_active,
  output logic pll_bypass,
  output logic pll_enable,
  output logic bus_invert_apply,
  output logic bus_invert_enable,
  output logic compensation_freeze,
  output logic refresh_mode_select,
  output logic [1:0] burst_length_field,
  output logic [2:0] speed_config,
  output logic auto_mask_enable,
  output logic [1:0] auto_mask_pattern,
  output logic beat0_write_en,
  output logic beat1_write_en,
  output logic [9:0] termination_config,
  output logic [9:0] driver_and_data_termination_config,
  output logic cmd_read,
  output logic cmd_write,
  output logic cmd_refresh,
  output logic cmd_overlap_refresh,
  output logic cmd_mode_set
);

  // ==========================================================================
  // State types, one packed struct per clock domain
  typedef struct packed {
    logic sel_s1;
    logic sel_s2;
    logic mf_s1;
    logic mf_s2;
    logic [2*MDL_PIN_W-1:0] in_s1;
    logic [2*MDL_PIN_W-1:0] in_s2;
    logic [2*MDL_OUT_W-1:0] map1;
    logic [2*MDL_OUT_W-1:0] map2;
    logic [MDL_OUT_W-1:0] echo_rise;
    logic [MDL_OUT_W-1:0] echo_fall;
    logic [2*MDL_OUT_W-1:0] xfer;
    logic req;
    logic ack_s1;
    logic ack_s2;
    mdl_mrs_t mrs_state;
    logic [2:0] mrs_num;
    logic [2:0] mrs_b0;
    logic [MDL_NUM_REGS-1:0][MDL_CFG_W-1:0] cfg;
    logic rd;
    logic wr;
    logic rf;
    logic orf;
    logic ms;
  } mdl_core_t;

  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic req_s1;
    logic req_s2;
    logic ack;
    logic act_s1;
    logic act_s2;
    logic [MDL_OUT_W-1:0] out_rise;
    logic [MDL_OUT_W-1:0] out_fall;
  } mdl_link_t;

  mdl_core_t core_reg;
  mdl_core_t core_next;
  mdl_link_t link_reg;
  mdl_link_t link_next;

  // ==========================================================================
  // Pin-fixed echo map; mirroring swaps what a pin carries, not where it goes
  function automatic logic [MDL_OUT_W-1:0] mdl_place(
    input logic [MDL_PIN_W-1:0] p
  );
    logic [MDL_OUT_W-1:0] o;
    o = '0;
    o[4] = p[8];
    o[0] = p[6];
    o[1] = p[MDL_IDX_DK0];
    o[3] = p[5];
    o[6] = p[12];
    o[2] = p[10];
    o[8] = p[13];
    o[7] = p[7];
    o[5] = p[11];
    if (MDL_X36) begin
      o[18] = p[4];
      o[20] = p[MDL_IDX_CS];
      o[22] = p[2];
      o[24] = p[0];
      o[14] = p[MDL_IDX_DK1];
      o[19] = p[3];
      o[21] = p[MDL_IDX_WE];
      o[25] = p[MDL_IDX_REF];
      o[26] = p[1];
      o[MDL_DQ_W+2] = p[MDL_IDX_DPR];
      o[23] = p[9];
    end else begin
      // The narrow part has no second write clock to echo
      o[9] = p[4];
      o[11] = p[MDL_IDX_CS];
      o[13] = p[2];
      o[15] = p[0];
      o[10] = p[3];
      o[12] = p[MDL_IDX_WE];
      o[16] = p[MDL_IDX_REF];
      o[17] = p[1];
      o[MDL_DQ_W+1] = p[MDL_IDX_DPR];
      o[14] = p[9];
    end
    return o;
  endfunction : mdl_place

  // Undo the clam-shell swaps so commands decode by function
  function automatic logic [MDL_PIN_W-1:0] mdl_unmirror(
    input logic [MDL_PIN_W-1:0] p,
    input logic mf
  );
    logic [MDL_PIN_W-1:0] l;
    l = p;
    if (mf) begin
      l[0] = p[1];
      l[1] = p[0];
      l[3] = p[4];
      l[4] = p[3];
      l[2] = p[MDL_IDX_REF];
      l[MDL_IDX_REF] = p[2];
      l[MDL_IDX_CS] = p[MDL_IDX_WE];
      l[MDL_IDX_WE] = p[MDL_IDX_CS];
      l[5] = p[6];
      l[6] = p[5];
      l[12] = p[13];
      l[13] = p[12];
      l[9] = p[MDL_IDX_DPR];
      l[MDL_IDX_DPR] = p[9];
    end
    return l;
  endfunction : mdl_unmirror

  // ==========================================================================
  // Command clock domain
  logic loop;
  logic [MDL_PIN_W-1:0] lg;
  logic [2:0] code;

  assign loop = ~core_reg.sel_s2;
  assign lg =
    mdl_unmirror(core_reg.in_s2[MDL_PIN_W-1:0], core_reg.mf_s2);
  assign code = {lg[MDL_IDX_CS], lg[MDL_IDX_WE], lg[MDL_IDX_REF]};

  // Next state: synchronisers, echo pipeline, crossing, command decode
  always_comb begin
    core_next = core_reg;
    core_next.sel_s1 = echo_select_n;
    core_next.sel_s2 = core_reg.sel_s1;
    core_next.mf_s1 = mirror_flip;
    core_next.mf_s2 = core_reg.mf_s1;
    core_next.in_s1 = {write_data_clock_fall, ctl_n_fall, addr_fall,
                       write_data_clock_rise, ctl_n_rise, addr_rise};
    core_next.in_s2 = core_reg.in_s1;
    // Two sync stages plus three pipeline stages give five cycles
    core_next.map1 = {mdl_place(core_reg.in_s2[2*MDL_PIN_W-1:MDL_PIN_W]),
                      mdl_place(core_reg.in_s2[MDL_PIN_W-1:0])};
    core_next.map2 = core_reg.map1;
    // Raw samples only: the inversion setting never touches this path
    core_next.echo_rise =
      loop ? core_reg.map2[MDL_OUT_W-1:0] : '0;
    core_next.echo_fall =
      loop ? ~core_reg.map2[2*MDL_OUT_W-1:MDL_OUT_W] : '0;
    // Toggle handshake; the link side samples only whole, held words
    core_next.ack_s1 = link_reg.ack;
    core_next.ack_s2 = core_reg.ack_s1;
    if (core_reg.req == core_reg.ack_s2) begin
      core_next.xfer = {core_reg.echo_fall, core_reg.echo_rise};
      core_next.req = ~core_reg.req;
    end
    core_next.rd = 1'b0;
    core_next.wr = 1'b0;
    core_next.rf = 1'b0;
    core_next.orf = 1'b0;
    core_next.ms = 1'b0;
    // Nothing decodes in loopback, so training cannot disturb memory
    unique case (core_reg.mrs_state)
      MDL_MRS_IDLE: begin
        if (!loop) begin
          if (!lg[MDL_IDX_DPR] && core_reg.cfg[0][MDL_R0_RM]) begin
            core_next.orf = 1'b1;
          end
          unique case (code)
            MDL_CMD_READ: core_next.rd = 1'b1;
            MDL_CMD_WRITE: core_next.wr = 1'b1;
            MDL_CMD_REFRESH: core_next.rf = 1'b1;
            MDL_CMD_MRS: begin
              core_next.mrs_num = lg[2:0];
              core_next.mrs_b0 = lg[5:3];
              core_next.mrs_state = MDL_MRS_BEAT1;
            end
            default: begin
            end
          endcase
        end
      end
      MDL_MRS_BEAT1: begin
        // Second address beat is taken on the next rising edge only
        core_next.mrs_state = MDL_MRS_IDLE;
        if (!loop) begin
          core_next.ms = 1'b1;
          // Registers 4 to 7 hold no fields; writes there are dropped
          if (!core_reg.mrs_num[2]) begin
            core_next.cfg[core_reg.mrs_num[1:0]] =
              {1'b0, core_reg.mrs_b0, lg[5:0]};
          end
        end
      end
    endcase
    if (sys_rst) begin
      core_next = '0;
      core_next.sel_s1 = 1'b1;
      core_next.sel_s2 = 1'b1;
      core_next.in_s1 = '1;
      core_next.in_s2 = '1;
      core_next.mrs_state = MDL_MRS_IDLE;
      core_next.cfg[0] = MDL_CFG0_RST;
      core_next.cfg[1] = MDL_CFG1_RST;
      core_next.cfg[2] = MDL_CFG2_RST;
      core_next.cfg[3] = MDL_CFG3_RST;
    end
  end

  // Register the command clock state
  always_ff @(posedge core_clk) begin
    core_reg <= core_next;
  end

  // ==========================================================================
  // Read clock domain: output stage for the echoed words
  always_comb begin
    link_next = link_reg;
    link_next.rst_s1 = sys_rst;
    link_next.rst_s2 = link_reg.rst_s1;
    link_next.req_s1 = core_reg.req;
    link_next.req_s2 = link_reg.req_s1;
    link_next.act_s1 = core_reg.sel_s2;
    link_next.act_s2 = link_reg.act_s1;
    // xfer is held steady from req toggle until the ack returns
    if (link_reg.req_s2 != link_reg.ack) begin
      link_next.out_rise = core_reg.xfer[MDL_OUT_W-1:0];
      link_next.out_fall = core_reg.xfer[2*MDL_OUT_W-1:MDL_OUT_W];
      link_next.ack = ~link_reg.ack;
    end
    if (link_reg.rst_s2) begin
      link_next.req_s1 = 1'b0;
      link_next.req_s2 = 1'b0;
      link_next.ack = 1'b0;
      link_next.act_s1 = 1'b1;
      link_next.act_s2 = 1'b1;
      link_next.out_rise = '0;
      link_next.out_fall = '0;
    end
  end

  // Register the read clock state
  always_ff @(posedge read_data_clock) begin
    link_reg <= link_next;
  end

  // ==========================================================================
  // Outputs
  assign echo_dq_rise = core_reg.echo_rise[MDL_DQ_W-1:0];
  assign echo_dq_fall = core_reg.echo_fall[MDL_DQ_W-1:0];
  assign echo_invert_rise = core_reg.echo_rise[MDL_OUT_W-1:MDL_DQ_W];
  assign echo_invert_fall = core_reg.echo_fall[MDL_OUT_W-1:MDL_DQ_W];
  assign dq_rise_out = link_reg.out_rise[MDL_DQ_W-1:0];
  assign dq_fall_out = link_reg.out_fall[MDL_DQ_W-1:0];
  assign data_invert_flag_rise = link_reg.out_rise[MDL_OUT_W-1:MDL_DQ_W];
  assign data_invert_flag_fall = link_reg.out_fall[MDL_OUT_W-1:MDL_DQ_W];
  assign link_echo_active = ~link_reg.act_s2;

  // Loopback status; the PLL enable bit itself is never touched here
  assign loopback_active = loop;
  assign self_refresh_active = loop;
  assign pll_bypass = loop;
  assign pll_enable = core_reg.cfg[1][MDL_R1_PLL];
  assign bus_invert_apply = core_reg.cfg[0][MDL_R0_DI] & ~loop;

  // Decoded mode fields
  assign bus_invert_enable = core_reg.cfg[0][MDL_R0_DI];
  assign compensation_freeze = core_reg.cfg[0][MDL_R0_FZ];
  assign refresh_mode_select = core_reg.cfg[0][MDL_R0_RM];
  assign burst_length_field = core_reg.cfg[0][MDL_R0_BL_LO+1:MDL_R0_BL_LO];
  assign speed_config = core_reg.cfg[0][MDL_R0_SPEED_LO+2:MDL_R0_SPEED_LO];
  assign auto_mask_enable = core_reg.cfg[1][MDL_R1_ADM];
  assign auto_mask_pattern =
    core_reg.cfg[1][MDL_R1_DMP_LO+1:MDL_R1_DMP_LO];
  assign termination_config = core_reg.cfg[2];
  assign driver_and_data_termination_config = core_reg.cfg[3];

  // Beat write enables: both beats unless auto-mask is on, then pattern 00 beat0, 10 beat1, else neither
  assign beat0_write_en = ~auto_mask_enable |
    (auto_mask_pattern == MDL_DMP_BEAT0);
  assign beat1_write_en = ~auto_mask_enable |
    (auto_mask_pattern == MDL_DMP_BEAT1);

  // Command strobes
  assign cmd_read = core_reg.rd;
  assign cmd_write = core_reg.wr;
  assign cmd_refresh = core_reg.rf;
  assign cmd_overlap_refresh = core_reg.orf;
  assign cmd_mode_set = core_reg.ms;

endmodule : mdl_deskew_cfg
`default_nettype wire

// file: test/mdl_deskew_cfg_sva.sv
// Concurrent checks on the loopback and mode configuration block ports
`timescale 1ns/1ps
`default_nettype none
module mdl_deskew_cfg_sva
  import mdl_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic read_data_clock,
  input wire logic [13:0] addr_rise,
  input wire logic [13:0] addr_fall,
  input wire logic [3:0] ctl_n_rise,
  input wire logic [1:0] write_data_clock_rise,
  input wire logic [26:0] echo_dq_rise,
  input wire logic [26:0] echo_dq_fall,
  input wire logic [2:0] echo_invert_rise,
  input wire logic loopback_active,
  input wire logic self_refresh_active,
  input wire logic pll_bypass,
  input wire logic pll_enable,
  input wire logic bus_invert_apply,
  input wire logic bus_invert_enable,
  input wire logic auto_mask_enable,
  input wire logic [1:0] auto_mask_pattern,
  input wire logic beat0_write_en,
  input wire logic beat1_write_en,
  input wire logic [9:0] termination_config,
  input wire logic cmd_read,
  input wire logic cmd_write,
  input wire logic cmd_refresh,
  input wire logic cmd_overlap_refresh,
  input wire logic cmd_mode_set
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // ==========================================================================
  // Echo pipeline must be full before the five-cycle relation can hold
  sequence loop_steady;
    loopback_active [*8];
  endsequence

  chk_echo_rise:
    assert property (loop_steady |-> echo_dq_rise[24] == $past(addr_rise[0], 5)
      && echo_dq_rise[1] == $past(write_data_clock_rise[0], 5))
    else $error("rise echo wrong");
  chk_echo_fall:
    assert property (loop_steady |->
      echo_dq_fall[24] == !$past(addr_fall[0], 5))
    else $error("fall echo wrong");
  chk_echo_invert:
    assert property (loop_steady |->
      echo_invert_rise[2] == $past(ctl_n_rise[3], 5))
    else $error("invert flag echo wrong");
  chk_invert_off:
    assert property (bus_invert_apply == (bus_invert_enable && !loopback_active))
    else $error("bus inversion in loopback");
  chk_cmd_block:
    assert property (loopback_active && $past(loopback_active) |-> !(cmd_read
      || cmd_write || cmd_refresh || cmd_overlap_refresh || cmd_mode_set))
    else $error("command taken in loopback");
  chk_self_refresh:
    assert property (self_refresh_active == loopback_active
      && pll_bypass == loopback_active)
    else $error("refresh or bypass wrong");
  chk_pll_keep:
    assert property (loopback_active != $past(loopback_active)
      |-> pll_enable == $past(pll_enable))
    else $error("pll setting moved");
  chk_mask_beat:
    assert property ({beat1_write_en, beat0_write_en} == (!auto_mask_enable ?
      2'h3 : auto_mask_pattern == 2'h0 ? 2'h1 : auto_mask_pattern == 2'h2 ?
      2'h2 : 2'h0))
    else $error("beat enable wrong");
  chk_cfg_hold:
    assert property (!cmd_mode_set |-> $stable({pll_enable, bus_invert_enable,
      auto_mask_enable, termination_config}))
    else $error("config moved without mode set");
  chk_mrs_pulse:
    assert property (cmd_mode_set |=> !cmd_mode_set)
    else $error("mode set pulse too long");
endmodule : mdl_deskew_cfg_sva
`default_nettype wire

// file: test/mdl_ctrl_model.sv
// Controller model driving training pins and mode set commands
`timescale 1ns/1ps
`default_nettype none
module mdl_ctrl_model
  import mdl_pkg::*;
#(
  parameter int QUIET = 16,
  parameter int MRD = 8
)
(
  input wire logic core_clk,
  output logic echo_select_n,
  output logic mirror_flip,
  output logic [13:0] addr_rise,
  output logic [13:0] addr_fall,
  output logic [3:0] ctl_n_rise,
  output logic [3:0] ctl_n_fall,
  output logic [1:0] write_data_clock_rise,
  output logic [1:0] write_data_clock_fall
);
  // ==========================================================================
  // Pin vector bit pairs exchanged by the mirror level
  localparam int SWP [14] = '{0, 1, 3, 4, 2, 16, 14, 15, 5, 6, 12, 13, 9, 17};

  // Idle pins at time zero: no command, loopback off
  initial begin
    echo_select_n = 1'b1;
    mirror_flip = 1'b0;
    {write_data_clock_rise, ctl_n_rise, addr_rise} = 20'hfc000;
    {write_data_clock_fall, ctl_n_fall, addr_fall} = 20'hfc000;
  end

  // One rise and fall pin sample, launched on the next edge
  task automatic drive(input logic [19:0] r, input logic [19:0] f);
    @(posedge core_clk);
    {write_data_clock_rise, ctl_n_rise, addr_rise} <= r;
    {write_data_clock_fall, ctl_n_fall, addr_fall} <= f;
  endtask : drive

  // No command; unused address lines keep moving so stale values show
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge core_clk);
      ctl_n_rise <= 4'hf;
      ctl_n_fall <= 4'hf;
      // Port A9 stays high: it carries the overlap strobe when mirrored
      addr_rise <= ~addr_rise | 14'h200;
      addr_fall <= ~addr_fall;
    end
  endtask : idle

  // Quiet gaps on both sides of the select change
  task automatic loop_mode(input logic on);
    idle(QUIET);
    @(posedge core_clk);
    echo_select_n <= !on;
    idle(QUIET);
  endtask : loop_mode

  // Logical pin vector to port vector for one mirror level
  function automatic logic [19:0] mirror_pins(input logic [19:0] v,
                                              input logic mf);
    logic [19:0] s;
    s = v;
    for (int i = 0; i < 14; i += 2) begin
      if (mf) begin
        s[SWP[i]] = v[SWP[i+1]];
        s[SWP[i+1]] = v[SWP[i]];
      end
    end
    return s;
  endfunction : mirror_pins

  // One command from logical {dpr, ref, we, cs}, then one idle cycle
  task automatic command(input logic [3:0] c);
    drive(mirror_pins({2'h3, c, 14'h0}, mirror_flip), 20'hfffff);
    idle(1);
  endtask : command

  // Two-beat mode set from logical address bits, then the settle wait
  task automatic mode_set(input logic [2:0] rg, input logic [2:0] f0,
                          input logic [5:0] f1, input logic mf);
    logic [19:0] b0;
    logic [19:0] b1;
    if (mf !== mirror_flip) begin
      @(posedge core_clk);
      mirror_flip <= mf;
      idle(4);
    end
    b0 = mirror_pins({6'h38, 8'h0, f0, rg}, mf);
    b1 = mirror_pins({6'h3f, 8'h0, f1}, mf);
    drive(b0, ~b0);
    drive(b1, ~b1);
    idle(MRD);
  endtask : mode_set
endmodule : mdl_ctrl_model
`default_nettype wire

// file: test/mdl_deskew_cfg_tb.sv
// Self-checking bench for the loopback echo and mode register block
`timescale 1ns/1ps
`default_nettype none
module mdl_deskew_cfg_tb;
  import mdl_pkg::*;
  // Echo bit for each pin vector bit; 27 to 29 are the invert flags
  localparam int OUT [20] = '{24, 26, 22, 19, 18, 3, 0, 7, 4, 23, 2, 5, 6,
    8, 20, 21, 25, 29, 1, 14};
  typedef struct packed {
    logic [2:0] rg;
    logic [2:0] f0;
    logic [5:0] f1;
    logic mf;
  } mdl_row_t;
  // Register, beat0 field, beat1 field, mirror level
  localparam mdl_row_t ROWS [7] = '{'{3'h0, 3'h3, 6'h1d, 1'b0},
    '{3'h1, 3'h5, 6'h01, 1'b1}, '{3'h2, 3'h6, 6'h2a, 1'b0},
    '{3'h3, 3'h1, 6'h15, 1'b1}, '{3'h6, 3'h7, 6'h3f, 1'b0},
    '{3'h1, 3'h1, 6'h00, 1'b0}, '{3'h1, 3'h3, 6'h01, 1'b1}};
  // Logical {dpr, ref, we, cs}, then {overlap, refresh, read, write, mode}
  localparam logic [8:0] CMDS [6] = '{9'h182, 9'h1c4, 9'h148, 9'h0f0,
    9'h0d4, 9'h1e0};
  logic core_clk = 1'b0;
  logic read_data_clock = 1'b0;
  logic sys_rst = 1'b1;
  logic echo_select_n, mirror_flip, link_echo_active, loopback_active;
  logic [13:0] addr_rise, addr_fall;
  logic [3:0] ctl_n_rise, ctl_n_fall;
  logic [1:0] write_data_clock_rise, write_data_clock_fall;
  logic [26:0] echo_dq_rise, echo_dq_fall, dq_rise_out, dq_fall_out;
  logic [2:0] echo_invert_rise, echo_invert_fall, speed_config;
  logic [2:0] data_invert_flag_rise, data_invert_flag_fall;
  logic self_refresh_active, pll_bypass, pll_enable, bus_invert_apply;
  logic bus_invert_enable, compensation_freeze, refresh_mode_select;
  logic auto_mask_enable, beat0_write_en, beat1_write_en, cmd_read;
  logic cmd_write, cmd_refresh, cmd_overlap_refresh, cmd_mode_set;
  logic [1:0] burst_length_field, auto_mask_pattern;
  logic [9:0] termination_config, driver_and_data_termination_config;
  logic [9:0] cfg_m [4];
  logic [29:0] pat;
  int n_fail = 0;
  int compares = 0;

  mdl_deskew_cfg uut (.*);
  mdl_ctrl_model ctrl (.*);

  // ==========================================================================
  // Clocks: 5 ns command clock, 6 ns link clock
  always #2.5 core_clk = ~core_clk;
  always #3 read_data_clock = ~read_data_clock;

  task automatic chk(input logic [29:0] got, input logic [29:0] exp,
                     input logic [29:0] msk, input string what);
    compares++;
    if ((got & msk) !== (exp & msk)) begin
      n_fail++;
      $display("CHECK FAILED %0t %s", $time, what);
    end
  endtask : chk

  // Mapped echo word; unmapped outputs are left unchecked
  function automatic logic [29:0] exp_echo(input logic [19:0] p);
    logic [29:0] e;
    e = '0;
    for (int i = 0; i < 20; i++) e[OUT[i]] = p[i];
    return e;
  endfunction : exp_echo

  task automatic chk_cfg();
    @(negedge core_clk);
    chk(30'({1'b0, speed_config, 1'b0, bus_invert_enable,
      compensation_freeze, refresh_mode_select, burst_length_field}),
      30'(cfg_m[0]), '1, "config 0");
    chk(30'({1'b0, auto_mask_pattern, auto_mask_enable, 5'h0,
      pll_enable}), 30'(cfg_m[1]), '1, "config 1");
    chk(30'(termination_config), 30'(cfg_m[2]), '1, "config 2");
    chk(30'(driver_and_data_termination_config), 30'(cfg_m[3]), '1,
      "config 3");
  endtask : chk_cfg

  task automatic report_and_stop();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  // Main sequence: mode rows, loopback echo, link copy, reset again
  initial begin
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    cfg_m = '{MDL_CFG0_RST, MDL_CFG1_RST, MDL_CFG2_RST, MDL_CFG3_RST};
    ctrl.idle(2);
    chk_cfg();
    foreach (ROWS[i]) begin
      ctrl.mode_set(ROWS[i].rg, ROWS[i].f0, ROWS[i].f1, ROWS[i].mf);
      if (ROWS[i].rg < 3'h4)
        cfg_m[ROWS[i].rg[1:0]] = {1'b0, ROWS[i].f0, ROWS[i].f1};
      chk_cfg();
    end
    $display("test mode rows done");
    // Commands on mirrored pins with overlapped refresh selected
    foreach (CMDS[i]) begin
      ctrl.command(CMDS[i][8:5]);
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      chk(30'({cmd_overlap_refresh, cmd_refresh, cmd_read,
        cmd_write, cmd_mode_set}), 30'(CMDS[i][4:0]), '1, "command");
    end
    $display("test commands done");
    ctrl.loop_mode(1'b1);
    @(negedge core_clk);
    chk(30'({loopback_active, self_refresh_active, pll_bypass,
      pll_enable, bus_invert_apply}), 30'h1e, '1, "loop entry");
    // Walking one: ctl bits low look like commands, which must be ignored
    for (int i = 0; i < 20; i++) begin
      ctrl.drive(20'h1 << i, ~(20'h1 << i));
      repeat (7) @(posedge core_clk);
      @(negedge core_clk);
      pat = exp_echo(20'h1 << i);
      chk({echo_invert_rise, echo_dq_rise}, pat, exp_echo('1),
        "rise");
      chk({echo_invert_fall, echo_dq_fall}, pat, exp_echo('1),
        "fall");
    end
    repeat (30) @(posedge core_clk);
    chk({data_invert_flag_rise, dq_rise_out}, pat, exp_echo('1), "link");
    chk({data_invert_flag_fall, dq_fall_out}, pat, exp_echo('1),
      "link fall");
    chk(30'(link_echo_active), 30'h1, '1, "link active");
    ctrl.mode_set(3'h1, 3'h0, 6'h00, 1'b1);
    chk_cfg();
    ctrl.loop_mode(1'b0);
    @(negedge core_clk);
    chk(30'({loopback_active, pll_enable, bus_invert_apply}),
      30'h3, '1, "loop exit");
    $display("test loopback done");
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    cfg_m = '{MDL_CFG0_RST, MDL_CFG1_RST, MDL_CFG2_RST, MDL_CFG3_RST};
    ctrl.idle(2);
    chk_cfg();
    chk({data_invert_flag_rise, dq_rise_out}, 30'h0, '1, "link reset");
    $display("test reset done");
    report_and_stop();
  end

  // Tests take under 1000 cycles; a hang past 5000 counts as a failure
  initial begin
    repeat (5000) @(posedge core_clk);
    n_fail++;
    report_and_stop();
  end
endmodule : mdl_deskew_cfg_tb

bind mdl_deskew_cfg mdl_deskew_cfg_sva sva_i (.*);
`default_nettype wire
